/* common/diag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
  logic rd;
  logic [2:0] idx;
  logic [7:0] rdata;
  logic wr;
  logic [2:0] widx;
  logic [7:0] wdata;

  modport master(output rd, output idx, output wr, output widx, output wdata, input rdata);
  modport store(input rd, input idx, input wr, input widx, input wdata, output rdata);
endinterface
`default_nettype wire

/* common/enc_map.svh */
`ifndef ENC_MAP_SVH
`define ENC_MAP_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STEPS 8'h04
`define REG_SPAN 8'h08
`define REG_MADDR 8'h0c
`define REG_STATUS 8'h10
`define REG_MASK 8'h14
`define REG_POS 8'h18
`define REG_WRAP 8'h1c

// --------------------------------------------------------------------------
// Control fields and reset values
// --------------------------------------------------------------------------
`define CTRL_DIR 0
`define CTRL_EXT 1
`define CTRL_RESCALE 2
`define CTRL_RESET 3'h6
`define STEPS_RESET 16'h1000
`define SPAN_ST_RESET 32'h0000_1000
`define SPAN_MT_RESET 32'h0100_0000
`define MADDR_RESET 8'h02

// --------------------------------------------------------------------------
// Event bits
// --------------------------------------------------------------------------
`define EV_WRAP_IN 0
`define EV_WRAP_OUT 1
`define EV_DIAG 2

// --------------------------------------------------------------------------
// Diagnostic block
// --------------------------------------------------------------------------
`define DIAG_LEN 3'h6
`define DIAG_STAT1 8'h00
`define DIAG_STAT2 8'h0c
`define DIAG_STAT3 8'h00
`define DIAG_IDX_MADDR 3'h3
`define DIAG_IDX_MAKER_HI 3'h4
`define DIAG_IDX_MAKER_LO 3'h5

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define CLK_MHZ 200
`define FLASH_HALF_MS 250

`endif

/* common/enc_pkg.sv */
`default_nettype none
package enc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SPAN = 3'b010,
    ST_POS = 3'b100
  } div_state_t;

  typedef logic [2:0] event_t;
endpackage
`default_nettype wire

/* hw/diag_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "enc_map.svh"
module diag_store
  import enc_pkg::*;
#(
  // Arbitrary value, not a registered maker code
  parameter logic [15:0] MAKER_ID = 16'h0a5c
) (
  input wire logic clk,
  input wire logic rst_n,
  diag_if.store bus
);
  logic [7:0] mem_q [6];
  logic [7:0] mem_d [6];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      mem_d[i] = mem_q[i];
    end
    rdata_d = rdata_q;
    if (bus.wr && bus.widx < `DIAG_LEN) begin
      mem_d[bus.widx] = bus.wdata;
    end
    if (bus.rd && bus.idx < `DIAG_LEN) begin
      rdata_d = mem_q[bus.idx];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_q[0] <= `DIAG_STAT1;
      mem_q[1] <= `DIAG_STAT2;
      mem_q[2] <= `DIAG_STAT3;
      mem_q[`DIAG_IDX_MADDR] <= `MADDR_RESET;
      mem_q[`DIAG_IDX_MAKER_HI] <= MAKER_ID[15:8];
      mem_q[`DIAG_IDX_MAKER_LO] <= MAKER_ID[7:0];
      rdata_q <= 8'h00;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

/* hw/encoder_scaling_wrap_diag.sv */
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "enc_map.svh"
module encoder_scaling_wrap_diag
  import enc_pkg::*;
#(
  parameter bit MULTI_TURN = 1'b1,
  parameter logic [31:0] NATIVE_SPAN = 32'h0100_0000,
  parameter int CPR_BITS = 12,
  parameter logic [15:0] MAKER_ID = 16'h0a5c,
  parameter int FLASH_HALF_CYC = `FLASH_HALF_MS * `CLK_MHZ * 1000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [31:0] raw_count,
  input wire logic diag_req,
  output logic diag_valid,
  output logic [7:0] diag_data,
  output logic diag_last,
  output logic [31:0] position,
  output logic in_wrap,
  output logic led_green,
  output logic led_red,
  output logic irq
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // One restoring division step; remainder stays below the divisor
  function automatic logic [31:0] div_step(input logic [31:0] r, input logic b,
                                           input logic [31:0] d);
    logic [32:0] t;
    t = {r, b};
    if (t >= {1'b0, d}) begin
      t = t - {1'b0, d};
    end
    return t[31:0];
  endfunction

  // Native count to steps-per-turn resolution
  function automatic logic [31:0] scale_cnt(input logic [31:0] c, input logic [15:0] s);
    logic [47:0] p;
    p = c * s;
    return p[CPR_BITS +: 32];
  endfunction

  localparam logic [31:0] SPAN_RESET = MULTI_TURN ? `SPAN_MT_RESET : `SPAN_ST_RESET;
  localparam logic [31:0] FLASH_MAX = 32'(FLASH_HALF_CYC - 1);

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  // Sensor word is sampled from a gray-stable source; two stages only
  logic [31:0] cnt_s1_q, cnt_s2_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_s1_q <= 32'h0000_0000;
      cnt_s2_q <= 32'h0000_0000;
    end else begin
      cnt_s1_q <= raw_count;
      cnt_s2_q <= cnt_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [2:0] ctrl_q, ctrl_d;
  logic [15:0] steps_q, steps_d;
  logic [31:0] span_q, span_d;
  logic [7:0] maddr_q, maddr_d;
  event_t status_q, status_d, mask_q, mask_d, ev;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic cfg_wr;
  logic [31:0] pos_q, wrap_rem_q;
  logic wrap_q;
  diag_if dbus ();

  assign cfg_wr = wr && (addr == `REG_CTRL || addr == `REG_STEPS || addr == `REG_SPAN);

  always_comb begin
    ctrl_d = ctrl_q;
    steps_d = steps_q;
    span_d = span_q;
    maddr_d = maddr_q;
    mask_d = mask_q;
    status_d = status_q;
    rdata_d = 32'h0000_0000;
    if (wr) begin
      unique case (addr)
        `REG_CTRL: ctrl_d = wdata[2:0];
        `REG_STEPS: steps_d = (wdata[15:0] != 16'h0000) ? wdata[15:0] : steps_q;
        // Zero span would make the divider return the dividend unreduced as remainder
        `REG_SPAN: span_d = (wdata != 32'h0000_0000) ? wdata : span_q;
        `REG_MADDR: maddr_d = wdata[7:0];
        `REG_STATUS: status_d = status_q & ~wdata[2:0];
        `REG_MASK: mask_d = wdata[2:0];
        default: ;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    status_d = status_d | ev;
    if (rd) begin
      unique case (addr)
        `REG_CTRL: rdata_d = {29'h0, ctrl_q};
        `REG_STEPS: rdata_d = {16'h0, steps_q};
        `REG_SPAN: rdata_d = span_q;
        `REG_MADDR: rdata_d = {24'h0, maddr_q};
        `REG_STATUS: rdata_d = {29'h0, status_q};
        `REG_MASK: rdata_d = {29'h0, mask_q};
        `REG_POS: rdata_d = pos_q;
        `REG_WRAP: rdata_d = wrap_rem_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
      steps_q <= `STEPS_RESET;
      span_q <= SPAN_RESET;
      maddr_q <= `MADDR_RESET;
      status_q <= 3'h0;
      mask_q <= 3'h0;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      steps_q <= steps_d;
      span_q <= span_d;
      maddr_q <= maddr_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // --------------------------------------------------------------------------
  // Span folding and position
  // --------------------------------------------------------------------------
  div_state_t st_q, st_d;
  logic [31:0] rem_q, rem_d, dvd_q, dvd_d, smp_q, smp_d, bound_q, bound_d;
  logic [31:0] wrap_rem_d, pos_d, rem_nx, n_eff, c_eff, c_dir;
  logic [4:0] step_q, step_d;
  logic recalc_q, recalc_d, wrap_d;

  assign n_eff = scale_cnt(NATIVE_SPAN, steps_q);
  assign c_eff = scale_cnt(cnt_s2_q, steps_q);
  assign c_dir = ctrl_q[`CTRL_DIR] ? n_eff - 32'h1 - c_eff : c_eff;
  assign rem_nx = div_step(rem_q, dvd_q[31], span_q);

  always_comb begin
    st_d = st_q;
    rem_d = rem_nx;
    dvd_d = {dvd_q[30:0], 1'b0};
    step_d = step_q + 5'h1;
    smp_d = smp_q;
    bound_d = bound_q;
    wrap_rem_d = wrap_rem_q;
    pos_d = pos_q;
    wrap_d = wrap_q;
    recalc_d = recalc_q | cfg_wr;
    unique case (st_q)
      ST_IDLE: begin
        st_d = ST_SPAN;
        dvd_d = n_eff;
        rem_d = 32'h0;
        step_d = 5'h0;
        recalc_d = cfg_wr;
      end
      ST_SPAN: begin
        if (step_q == 5'h1f) begin
          // Remainder of scaled native span n_eff by span_q; zero when ratio is 2^k
          wrap_rem_d = rem_nx;
          bound_d = n_eff - rem_nx;
          st_d = ST_POS;
          smp_d = c_dir;
          dvd_d = c_dir;
          rem_d = 32'h0;
          step_d = 5'h0;
        end
      end
      ST_POS: begin
        if (step_q == 5'h1f) begin
          if (recalc_q || cfg_wr) begin
            // Operands may mix old and new settings; keep the last good result
            st_d = ST_IDLE;
          end else if (!ctrl_q[`CTRL_RESCALE]) begin
            pos_d = smp_q;
            wrap_d = 1'b0;
          end else if (wrap_rem_q != 32'h0 && smp_q >= bound_q) begin
            // Offset so the last count before zero reads span minus one
            pos_d = smp_q - bound_q + (span_q - wrap_rem_q);
            wrap_d = 1'b1;
          end else begin
            pos_d = rem_nx;
            wrap_d = 1'b0;
          end
          smp_d = c_dir;
          dvd_d = c_dir;
          rem_d = 32'h0;
          step_d = 5'h0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      rem_q <= 32'h0;
      dvd_q <= 32'h0;
      step_q <= 5'h0;
      smp_q <= 32'h0;
      bound_q <= 32'h0;
      wrap_rem_q <= 32'h0;
      pos_q <= 32'h0;
      wrap_q <= 1'b0;
      recalc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rem_q <= rem_d;
      dvd_q <= dvd_d;
      step_q <= step_d;
      smp_q <= smp_d;
      bound_q <= bound_d;
      wrap_rem_q <= wrap_rem_d;
      pos_q <= pos_d;
      wrap_q <= wrap_d;
      recalc_q <= recalc_d;
    end
  end

  // --------------------------------------------------------------------------
  // Diagnostic answer
  // --------------------------------------------------------------------------
  logic busy_q, busy_d, vld_q, vld_d, last_q, last_d;
  logic [2:0] idx_q, idx_d;

  always_comb begin
    busy_d = busy_q;
    idx_d = idx_q;
    vld_d = 1'b0;
    last_d = 1'b0;
    // Requests during an answer are dropped; only the MADDR byte of the block is writable
    if (!busy_q && diag_req) begin
      busy_d = 1'b1;
      idx_d = 3'h0;
    end else if (busy_q) begin
      vld_d = 1'b1;
      last_d = (idx_q == `DIAG_LEN - 3'h1);
      idx_d = idx_q + 3'h1;
      if (last_d) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      idx_q <= 3'h0;
      vld_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      idx_q <= idx_d;
      vld_q <= vld_d;
      last_q <= last_d;
    end
  end

  assign dbus.rd = busy_q;
  assign dbus.idx = idx_q;
  assign dbus.wr = wr && addr == `REG_MADDR;
  assign dbus.widx = `DIAG_IDX_MADDR;
  assign dbus.wdata = wdata[7:0];

  diag_store #(.MAKER_ID(MAKER_ID)) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .bus(dbus.store)
  );

  assign ev[`EV_WRAP_IN] = wrap_d && !wrap_q;
  assign ev[`EV_WRAP_OUT] = !wrap_d && wrap_q;
  assign ev[`EV_DIAG] = last_q;

  // --------------------------------------------------------------------------
  // Indicators
  // --------------------------------------------------------------------------
  logic [31:0] fl_q, fl_d;
  logic grn_q, grn_d;

  always_comb begin
    fl_d = fl_q + 32'h1;
    grn_d = grn_q;
    if (!wrap_q) begin
      fl_d = 32'h0;
      grn_d = 1'b1;
    end else if (fl_q >= FLASH_MAX) begin
      fl_d = 32'h0;
      grn_d = !grn_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fl_q <= 32'h0;
      grn_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
      grn_q <= grn_d;
    end
  end

  assign rdata = rdata_q;
  assign diag_valid = vld_q;
  assign diag_data = dbus.rdata;
  assign diag_last = last_q;
  assign position = pos_q;
  assign in_wrap = wrap_q;
  assign led_green = grn_q;
  // Red is owned by fault logic outside this block; never lit here
  assign led_red = 1'b0;
  assign irq = irq_q;
endmodule
`default_nettype wire

/* tb/enc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module enc_props #(
  parameter logic [15:0] MAKER_ID = 16'h0000,
  parameter int FLASH_HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [31:0] raw_count,
  input wire logic diag_req,
  input wire logic diag_valid,
  input wire logic [7:0] diag_data,
  input wire logic diag_last,
  input wire logic [31:0] position,
  input wire logic in_wrap,
  input wire logic led_green,
  input wire logic led_red,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [2:0] run_q, run_d;
  int stay_q, stay_d;
  logic green_q, green_d;
  always_comb begin
    run_d = (run_q == 3'h7) ? run_q : run_q + 3'h1;
    stay_d = (in_wrap && led_green == green_q) ? stay_q + 1 : 0;
    green_d = led_green;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q <= 3'h0;
      stay_q <= 0;
      green_q <= 1'b0;
    end else begin
      run_q <= run_d;
      stay_q <= stay_d;
      green_q <= green_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence ans_s;
    diag_valid [*5] ##1 (diag_valid && diag_last) ##1 !diag_valid;
  endsequence
  sequence head_s;
    diag_data == 8'h00 ##1 diag_data == 8'h0c ##1 diag_data == 8'h00;
  endsequence
  diag_start_a: assert property ($rose(diag_valid) |-> $past(diag_req, 2))
    else $error("answer without request");
  diag_len_a: assert property ($rose(diag_valid) |-> ans_s)
    else $error("answer not six bytes");
  diag_head_a: assert property ($rose(diag_valid) |-> head_s)
    else $error("status bytes wrong");
  diag_maker_a: assert property (diag_last |-> diag_valid && diag_data == MAKER_ID[7:0]
    && $past(diag_data) == MAKER_ID[15:8]) else $error("maker bytes wrong");
  red_off_a: assert property (led_red == 1'b0) else $error("red lit");
  green_on_a: assert property (run_q == 3'h7 && !in_wrap && !$past(in_wrap) |-> led_green)
    else $error("green not steady");
  green_flash_a: assert property (stay_q <= FLASH_HALF_CYC + 2)
    else $error("green not flashing");
  wrap_jump_a: assert property ($rose(in_wrap) || $fell(in_wrap) |-> $changed(position))
    else $error("no jump at region edge");
  pos_read_a: assert property (rd && addr == 8'h18 |=>
    rdata == position || rdata == $past(position)) else $error("position read wrong");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not idle");
  irq_mask_a: assert property (wr && addr == 8'h14 && wdata == 32'h0 |-> ##[1:2] !irq)
    else $error("irq despite zero mask");
endmodule
bind encoder_scaling_wrap_diag enc_props #(.MAKER_ID(MAKER_ID),
  .FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (.clk, .rst_n, .addr, .wdata, .wr, .rd,
  .rdata, .raw_count, .diag_req, .diag_valid, .diag_data, .diag_last, .position,
  .in_wrap, .led_green, .led_red, .irq);
`default_nettype wire

/* tb/field_master.sv */
`timescale 1ns/1ps
`default_nettype none
module field_master (
  input wire logic clk,
  output logic diag_req,
  input wire logic diag_valid,
  input wire logic [7:0] diag_data,
  input wire logic diag_last
);
  initial diag_req = 1'b0;
  // Optional second request lands inside the answer and must be dropped
  task automatic poll(input bit spam, output logic [7:0] b [6], output int extra);
    int n;
    n = 0;
    extra = 0;
    @(posedge clk);
    diag_req <= 1'b1;
    @(posedge clk);
    diag_req <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      diag_req <= (spam && n == 2);
      #1;
      if (diag_valid === 1'b1 && n < 6) begin
        b[n] = diag_data;
        n++;
      end else if (diag_valid === 1'b1) begin
        extra++;
      end
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Arbitrary maker value
  localparam logic [15:0] MAKER = 16'h3c7e;
  localparam logic [39:0] DEFS [8] = '{40'h00_00000006, 40'h04_00001000,
    40'h08_01000000, 40'h0c_00000002, 40'h10_00000000, 40'h14_00000000,
    40'h1c_00000000, 40'h20_00000000};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] raw_count = 32'h0;
  logic diag_req, diag_valid, diag_last, in_wrap, led_green, led_red, irq;
  logic [31:0] rdata, position;
  logic [7:0] diag_data;
  logic [7:0] b [6];
  logic [7:0] exp_b [6];
  int extra;
  int fails = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  encoder_scaling_wrap_diag #(.MAKER_ID(MAKER), .FLASH_HALF_CYC(4)) u_dut (.clk, .rst_n,
    .addr, .wdata, .wr, .rd, .rdata, .raw_count, .diag_req, .diag_valid, .diag_data,
    .diag_last, .position, .in_wrap, .led_green, .led_red, .irq);
  field_master u_master (.clk, .diag_req, .diag_valid, .diag_data, .diag_last);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32(rdata, exp);
  endtask
  // Several 32-cycle refresh periods, enough for a config restart too
  task automatic pos_chk(input logic [31:0] c, input logic [31:0] p, input logic w);
    @(posedge clk);
    raw_count <= c;
    repeat (160) @(posedge clk);
    #1;
    chk32(position, p);
    chk32({31'h0, in_wrap}, {31'h0, w});
  endtask
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (DEFS[i]) rd_chk(DEFS[i][39:32], DEFS[i][31:0]);
    pos_chk(32'h4d2, 32'h4d2, 1'b0);
    chk32({31'h0, led_green}, 32'h1);
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h18, 32'h5);
    rd_chk(8'h08, 32'h0100_0000);
    rd_chk(8'h18, 32'h4d2);
    wr_reg(8'h08, 32'h64);
    pos_chk(32'h4d2, 32'h22, 1'b0);
    rd_chk(8'h1c, 32'h10);
    pos_chk(32'hffffef, 32'h63, 1'b0);
    pos_chk(32'hfffff0, 32'h54, 1'b1);
    chk32({31'h0, led_red}, 32'h0);
    pos_chk(32'hffffff, 32'h63, 1'b1);
    rd_chk(8'h10, 32'h1);
    wr_reg(8'h14, 32'h1);
    rd_chk(8'h14, 32'h1);
    chk32({31'h0, irq}, 32'h1);
    wr_reg(8'h10, 32'h1);
    rd_chk(8'h10, 32'h0);
    chk32({31'h0, irq}, 32'h0);
    pos_chk(32'h5, 32'h5, 1'b0);
    rd_chk(8'h10, 32'h2);
    wr_reg(8'h14, 32'h0);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h08, 32'h1000);
    pos_chk(32'hffffff, 32'hfff, 1'b0);
    rd_chk(8'h1c, 32'h0);
    wr_reg(8'h00, 32'h7);
    pos_chk(32'h4d2, 32'hb2d, 1'b0);
    wr_reg(8'h00, 32'h2);
    pos_chk(32'h12345, 32'h12345, 1'b0);
    wr_reg(8'h0c, 32'h5a);
    exp_b = '{8'h00, 8'h0c, 8'h00, 8'h5a, MAKER[15:8], MAKER[7:0]};
    u_master.poll(1'b1, b, extra);
    for (int i = 0; i < 6; i++) chk32({24'h0, b[i]}, {24'h0, exp_b[i]});
    chk32(32'(extra), 32'h0);
    rd_chk(8'h10, 32'h4);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
